//--- design/awl_pkg.sv
// Operation
// - Ten-stage samplers accept a level after three matching samples.
// - Bit needs level in upper stages then Null in lower; gap needs both Null.
// - Reject a bit closer than 8 or further than 12 samples from the last.
// - Gap timer checks Null every 10 samples; three Nulls re-enable reception.
// - Stored bit 32 is 0 for odd parity, 1 for even parity.
// - After 32 bits pulse word end, filter, then store in FIFO.
// - Store only when every enabled label and bit 9/10 check passes.
// - Storing sets data-ready; it clears once the FIFO is read empty.
// - Receive FIFO holds 32; full pin low; overflow overwrites the last entry.
// - Half-full pin low while the receive FIFO holds 16 or more.
// - Label match compares sixteen stored labels against received bits 1-8.
// - Label-access rising makes next 16 loads write label memory; reception suspended.
// - Label-access rising makes next 16 reads return stored labels.
// - Low-half then high-half load stores one word in the transmit FIFO.
// - Full transmit FIFO ignores loads; half pin high below 16 words.
// - Parity insertion makes bit 32 odd or even parity; otherwise sent unchanged.
// - Transmit go moves the oldest word out; first bit appears promptly.
// - Bit is 5 ticks level, 5 ticks Null; gap 40 ticks; low speed 8x.
// - Transmitter ready is high whenever the transmit FIFO is empty.
// - Loopback feeds receiver 1 direct, receiver 2 inverted; test forces Null.
// - Rate bit 0 selects 100 kbit/s, 1 selects 12.5 kbit/s.
// - Master clear stops links and empties FIFOs; control register kept.
// - Status read with select low drives 9 status bits, zeros above.
package awl_pkg;
   // Timing base
   localparam int         CLK_PERIOD_PS    = 25000;
   localparam int         SAMPLE_PERIOD_NS = 1000;
   localparam int         SAMPLE_DIV       = (SAMPLE_PERIOD_NS * 1000) / CLK_PERIOD_PS;
   localparam logic [5:0] SAMPLE_DIV_LAST  = 6'(SAMPLE_DIV - 1);
   localparam logic [2:0] SLOW_DIV_LAST    = 3'h7;
   // Receiver timing
   localparam logic [3:0] SPACE_RESTART    = 4'h1;
   localparam logic [3:0] BIT_SPACE_MIN    = 4'h8;
   localparam logic [3:0] BIT_SPACE_MAX    = 4'hc;
   localparam logic [3:0] GAP_SAMPLE_LAST  = 4'h9;
   localparam logic [1:0] GAP_NULLS_LAST   = 2'h2;
   localparam logic [4:0] WORD_LAST_BIT    = 5'h1f;
   // FIFO and label sizes
   localparam logic [5:0] FIFO_DEPTH       = 6'h20;
   localparam logic [5:0] HALF_MARK        = 6'h10;
   localparam logic [4:0] LABEL_COUNT      = 5'h10;
   // Transmit timing in ticks
   localparam logic [3:0] TX_LEVEL_TICKS   = 4'h5;
   localparam logic [3:0] TX_BIT_LAST      = 4'h9;
   localparam logic [5:0] TX_GAP_LAST      = 6'h27;
   // Control register fields
   localparam int RX1_RATE_LOW = 0;
   localparam int LABEL_ACCESS = 1;
   localparam int RX1_MATCH_EN = 2;
   localparam int RX2_MATCH_EN = 3;
   localparam int TX_PARITY_IN = 4;
   localparam int LOOPBACK_N   = 5;
   localparam int RX1_SDI_EN   = 6;
   localparam int RX1_SDI_B9   = 7;
   localparam int RX1_SDI_B10  = 8;
   localparam int RX2_SDI_EN   = 9;
   localparam int RX2_SDI_B9   = 10;
   localparam int RX2_SDI_B10  = 11;
   localparam int TX_PAR_EVEN  = 12;
   localparam int TX_RATE_LOW  = 13;
   localparam int RX2_RATE_LOW = 14;
   localparam int UNSCRAMBLE   = 15;
   localparam logic [15:0] CTRL_RESET = 16'h0030;
   // Bus map
   localparam logic [3:0] WB_CTRL_ADDR   = 4'h0;
   localparam logic [3:0] WB_STATUS_ADDR = 4'h4;
   // States
   typedef enum logic {RX_GAP = 1'b0, RX_WORD = 1'b1} awl_rx_state_t;
   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_BIT = 2'b01, TX_GAP = 2'b11} awl_tx_state_t;
endpackage

//--- design/awl_word_link.sv
`timescale 1ns/1ps
module awl_word_link (
   // System
   input  logic        clock,
   input  logic        rst,
   input  logic        masterClear,
   // Wishbone slave
   input  logic        wb_cyc_i,
   input  logic        wb_stb_i,
   input  logic        wb_we_i,
   input  logic [3:0]  wb_adr_i,
   input  logic [3:0]  wb_sel_i,
   input  logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic        wb_ack_o,
   // Line receiver levels, index 0 is receiver 1
   input  logic [1:0]  rxLineOne,
   input  logic [1:0]  rxLineZero,
   // Host parallel port
   input  logic [15:0] busIn,
   output logic [15:0] busOut,
   output logic        busOe,
   input  logic        byteSel,
   input  logic        rx1ReadStrobeN,
   input  logic        rx2ReadStrobeN,
   input  logic        txLoadLowN,
   input  logic        txLoadHighN,
   input  logic        statusReadN,
   input  logic        txGo,
   input  logic        testForceNull,
   // Flags
   output logic        rx1WordAvailN,
   output logic        rx2WordAvailN,
   output logic        rx1FifoFullN,
   output logic        rx2FifoFullN,
   output logic        rx1FifoHalfN,
   output logic        rx2FifoHalfN,
   output logic        txFifoFullN,
   output logic        txFifoHalfN,
   output logic        txReady,
   output logic [1:0]  wordEndPulse,
   // Line driver levels
   output logic        lineOutPos,
   output logic        lineOutNeg
);
   logic [15:0] ctrl;
   logic        clr;
   logic        wbReq;
   logic        ctrlWr;
   logic        lblStart;
   logic [8:0]  status;
   logic [5:0]  tickCnt;
   logic [2:0]  slowCnt;
   logic        tick;
   logic        slowTick;
   logic        txTick;
   logic [1:0]  rxTick;
   logic [1:0]  smpInOne;
   logic [1:0]  smpInZero;
   logic [9:0]  smpOne [2];
   logic [9:0]  smpZero [2];
   logic [1:0]  upOne;
   logic [1:0]  lvlBit;
   logic [1:0]  gapNull;
   logic [1:0]  bitCond;
   logic [1:0]  bitPrev;
   logic [1:0]  bitFire;
   logic [1:0]  clash;
   logic [1:0]  badSpace;
   logic [1:0]  wordDone;
   logic [1:0]  matchEn;
   logic [1:0]  sdiEn;
   logic [1:0]  sdiCmp [2];
   logic [1:0]  lblHit;
   logic [1:0]  pass;
   logic [1:0]  push;
   logic [1:0]  pop;
   logic [31:0] rawWord [2];
   logic [31:0] pushData [2];
   logic [31:0] asmWord [2];
   awl_pkg::awl_rx_state_t rxState [2];
   logic [3:0]  spacing [2];
   logic [3:0]  gapDiv [2];
   logic [1:0]  gapCnt [2];
   logic [4:0]  bitCnt [2];
   logic [31:0] rxMem [2][32];
   logic [4:0]  rxWr [2];
   logic [4:0]  rxRd [2];
   logic [5:0]  rxCnt [2];
   logic [1:0]  rxFull;
   logic [1:0]  rxHalf;
   logic [1:0]  rdy;
   logic [1:0]  strbPrev;
   logic [1:0]  loadPrev;
   logic [1:0]  rdEdge;
   logic [1:0]  ldEdge;
   logic [7:0]  lblMem [2][16];
   logic [4:0]  lblRd [2];
   logic [4:0]  lblWr [2];
   logic [1:0]  lblRdActive;
   logic [15:0] txHold;
   logic [31:0] txMem [32];
   logic [4:0]  txWr;
   logic [4:0]  txRd;
   logic [5:0]  txCnt;
   logic        txFull;
   logic        txPush;
   logic        txPop;
   logic [31:0] txWordOut;
   awl_pkg::awl_tx_state_t txState;
   logic [31:0] txShift;
   logic [3:0]  txPhase;
   logic [4:0]  txIdx;
   logic [5:0]  txGapCnt;
   logic        txOne;
   logic        txZero;

   // Bus decode
   assign clr      = rst | masterClear;
   assign wbReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign ctrlWr   = wbReq & wb_we_i & (wb_adr_i == awl_pkg::WB_CTRL_ADDR);
   assign lblStart = ctrlWr & wb_sel_i[0] & wb_dat_i[awl_pkg::LABEL_ACCESS] & ~ctrl[awl_pkg::LABEL_ACCESS];
   assign status   = {~txFifoHalfN, txFull, txReady, rxFull[1], rxHalf[1], rdy[1],
                      rxFull[0], rxHalf[0], rdy[0]};

   // Wishbone slave, control survives master clear
   always_ff @(posedge clock) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         ctrl     <= awl_pkg::CTRL_RESET;
      end else begin
         wb_ack_o <= wbReq;
         if (ctrlWr && wb_sel_i[0]) ctrl[7:0] <= wb_dat_i[7:0];
         if (ctrlWr && wb_sel_i[1]) ctrl[15:8] <= wb_dat_i[15:8];
         if (wbReq && !wb_we_i) begin
            if (wb_adr_i == awl_pkg::WB_CTRL_ADDR) wb_dat_o <= {16'h0, ctrl};
            else if (wb_adr_i == awl_pkg::WB_STATUS_ADDR) wb_dat_o <= {23'h0, status};
            else wb_dat_o <= 32'h0;
         end
      end
   end

   // Sample ticks at 1 us and 8 us
   assign tick     = tickCnt == awl_pkg::SAMPLE_DIV_LAST;
   assign slowTick = tick & (slowCnt == awl_pkg::SLOW_DIV_LAST);
   assign txTick   = ctrl[awl_pkg::TX_RATE_LOW] ? slowTick : tick;
   always_ff @(posedge clock) begin
      if (clr) begin
         tickCnt <= 6'h0;
         slowCnt <= 3'h0;
      end else begin
         tickCnt <= tick ? 6'h0 : tickCnt + 6'h1;
         if (tick) slowCnt <= slowCnt + 3'h1;
      end
   end

   // Receiver inputs, checks and filters
   always_comb begin
      smpInOne[0]  = ctrl[awl_pkg::LOOPBACK_N] ? rxLineOne[0] : txOne;
      smpInZero[0] = ctrl[awl_pkg::LOOPBACK_N] ? rxLineZero[0] : txZero;
      smpInOne[1]  = ctrl[awl_pkg::LOOPBACK_N] ? rxLineOne[1] : txZero;
      smpInZero[1] = ctrl[awl_pkg::LOOPBACK_N] ? rxLineZero[1] : txOne;
      rxTick[0]    = ctrl[awl_pkg::RX1_RATE_LOW] ? slowTick : tick;
      rxTick[1]    = ctrl[awl_pkg::RX2_RATE_LOW] ? slowTick : tick;
      matchEn      = {ctrl[awl_pkg::RX2_MATCH_EN], ctrl[awl_pkg::RX1_MATCH_EN]};
      sdiEn        = {ctrl[awl_pkg::RX2_SDI_EN], ctrl[awl_pkg::RX1_SDI_EN]};
      sdiCmp[0]    = {ctrl[awl_pkg::RX1_SDI_B10], ctrl[awl_pkg::RX1_SDI_B9]};
      sdiCmp[1]    = {ctrl[awl_pkg::RX2_SDI_B10], ctrl[awl_pkg::RX2_SDI_B9]};
      for (int r = 0; r < 2; r++) begin
         upOne[r]    = &smpOne[r][9:7];
         lvlBit[r]   = upOne[r] | (&smpZero[r][9:7]);
         gapNull[r]  = ~|{smpOne[r][9:7], smpZero[r][9:7], smpOne[r][2:0], smpZero[r][2:0]};
         bitCond[r]  = lvlBit[r] & ~|{smpOne[r][2:0], smpZero[r][2:0]};
         bitFire[r]  = rxTick[r] & bitCond[r] & ~bitPrev[r];
         clash[r]    = smpOne[r][0] & smpZero[r][0];
         badSpace[r] = (bitCnt[r] != 5'h0) &
                       ((spacing[r] < awl_pkg::BIT_SPACE_MIN) || (spacing[r] > awl_pkg::BIT_SPACE_MAX));
         rawWord[r]  = {upOne[r], asmWord[r][31:1]};
         wordDone[r] = (rxState[r] == awl_pkg::RX_WORD) & bitFire[r] & ~badSpace[r] & ~clash[r] &
                       ~ctrl[awl_pkg::LABEL_ACCESS] & (bitCnt[r] == awl_pkg::WORD_LAST_BIT);
         lblHit[r]   = 1'b0;
         for (int i = 0; i < 16; i++) begin
            if (lblMem[r][i] == rawWord[r][7:0]) lblHit[r] = 1'b1;
         end
         pass[r]     = (~matchEn[r] | lblHit[r]) & (~sdiEn[r] | (rawWord[r][9:8] == sdiCmp[r]));
         push[r]     = wordDone[r] & pass[r];
         pushData[r] = {~(^rawWord[r]), rawWord[r][30:0]};
         rxFull[r]   = rxCnt[r] == awl_pkg::FIFO_DEPTH;
         rxHalf[r]   = rxCnt[r] >= awl_pkg::HALF_MARK;
         lblRdActive[r] = ctrl[awl_pkg::LABEL_ACCESS] & (lblRd[r] != awl_pkg::LABEL_COUNT);
         pop[r]      = rdEdge[r] & byteSel & ~lblRdActive[r] & (rxCnt[r] != 6'h0);
      end
   end

   // Receiver samplers and word assembly
   always_ff @(posedge clock) begin
      for (int r = 0; r < 2; r++) begin
         if (clr) begin
            smpOne[r]  <= 10'h0;
            smpZero[r] <= 10'h0;
            bitPrev[r] <= 1'b0;
            rxState[r] <= awl_pkg::RX_GAP;
            spacing[r] <= 4'h0;
            gapDiv[r]  <= 4'h0;
            gapCnt[r]  <= 2'h0;
            bitCnt[r]  <= 5'h0;
            asmWord[r] <= 32'h0;
            wordEndPulse[r] <= 1'b0;
         end else begin
            wordEndPulse[r] <= wordDone[r];
            if (rxTick[r]) begin
               smpOne[r]  <= {smpOne[r][8:0], smpInOne[r]};
               smpZero[r] <= {smpZero[r][8:0], smpInZero[r]};
               bitPrev[r] <= bitCond[r];
               if (spacing[r] != 4'hf) spacing[r] <= spacing[r] + 4'h1;
               unique case (rxState[r])
                  awl_pkg::RX_GAP: begin
                     gapDiv[r] <= (gapDiv[r] == awl_pkg::GAP_SAMPLE_LAST) ? 4'h0 : gapDiv[r] + 4'h1;
                     if (ctrl[awl_pkg::LABEL_ACCESS]) gapCnt[r] <= 2'h0;
                     else if (gapDiv[r] == awl_pkg::GAP_SAMPLE_LAST) begin
                        if (!gapNull[r]) gapCnt[r] <= 2'h0;
                        else if (gapCnt[r] == awl_pkg::GAP_NULLS_LAST) begin
                           rxState[r] <= awl_pkg::RX_WORD;
                           gapCnt[r]  <= 2'h0;
                           bitCnt[r]  <= 5'h0;
                        end else gapCnt[r] <= gapCnt[r] + 2'h1;
                     end
                  end
                  awl_pkg::RX_WORD: begin
                     if (clash[r] || ctrl[awl_pkg::LABEL_ACCESS] || (bitFire[r] && badSpace[r]) ||
                         ((bitCnt[r] != 5'h0) && (spacing[r] > awl_pkg::BIT_SPACE_MAX))) begin
                        rxState[r] <= awl_pkg::RX_GAP;
                        gapDiv[r]  <= 4'h0;
                        gapCnt[r]  <= 2'h0;
                     end else if (bitFire[r]) begin
                        asmWord[r] <= rawWord[r];
                        spacing[r] <= awl_pkg::SPACE_RESTART;
                        bitCnt[r]  <= bitCnt[r] + 5'h1;
                        if (bitCnt[r] == awl_pkg::WORD_LAST_BIT) begin
                           rxState[r] <= awl_pkg::RX_GAP;
                           gapDiv[r]  <= 4'h0;
                        end
                     end
                  end
               endcase
            end
         end
      end
   end

   // Receive FIFOs and data-ready flags
   always_ff @(posedge clock) begin
      for (int r = 0; r < 2; r++) begin
         if (clr) begin
            rxWr[r]  <= 5'h0;
            rxRd[r]  <= 5'h0;
            rxCnt[r] <= 6'h0;
            rdy[r]   <= 1'b0;
         end else begin
            if (push[r] && rxFull[r] && !pop[r]) begin
               rxMem[r][rxWr[r] - 5'h1] <= pushData[r];
            end else if (push[r]) begin
               rxMem[r][rxWr[r]] <= pushData[r];
               rxWr[r] <= rxWr[r] + 5'h1;
            end
            if (pop[r]) rxRd[r] <= rxRd[r] + 5'h1;
            if (push[r] && !rxFull[r] && !pop[r]) rxCnt[r] <= rxCnt[r] + 6'h1;
            else if (pop[r] && !push[r]) rxCnt[r] <= rxCnt[r] - 6'h1;
            rdy[r] <= push[r] | (rdy[r] & (rxCnt[r] != 6'h0));
         end
      end
   end

   // Strobe edges
   assign rdEdge[0] = strbPrev[0] & ~rx1ReadStrobeN;
   assign rdEdge[1] = strbPrev[1] & ~rx2ReadStrobeN & rx1ReadStrobeN;
   assign ldEdge[0] = loadPrev[0] & ~txLoadLowN;
   assign ldEdge[1] = loadPrev[1] & ~txLoadHighN;
   always_ff @(posedge clock) begin
      if (clr) begin
         strbPrev <= 2'b11;
         loadPrev <= 2'b11;
      end else begin
         strbPrev <= {rx2ReadStrobeN, rx1ReadStrobeN};
         loadPrev <= {txLoadHighN, txLoadLowN};
      end
   end

   // Label memory access sequences
   always_ff @(posedge clock) begin
      for (int r = 0; r < 2; r++) begin
         if (clr) begin
            lblRd[r] <= awl_pkg::LABEL_COUNT;
            lblWr[r] <= awl_pkg::LABEL_COUNT;
         end else if (lblStart) begin
            lblRd[r] <= 5'h0;
            lblWr[r] <= 5'h0;
         end else begin
            if (rdEdge[r] && lblRdActive[r]) lblRd[r] <= lblRd[r] + 5'h1;
            if (ldEdge[r] && ctrl[awl_pkg::LABEL_ACCESS] && lblWr[r] != awl_pkg::LABEL_COUNT) begin
               lblMem[r][lblWr[r][3:0]] <= busIn[7:0];
               lblWr[r] <= lblWr[r] + 5'h1;
            end
         end
      end
   end

   // Host data bus driver
   always_ff @(posedge clock) begin
      if (clr) begin
         busOut <= 16'h0;
         busOe  <= 1'b0;
      end else begin
         busOe <= ~rx1ReadStrobeN | ~rx2ReadStrobeN | (~statusReadN & ~byteSel);
         if (rdEdge[0] && lblRdActive[0]) busOut <= {8'h0, lblMem[0][lblRd[0][3:0]]};
         else if (rdEdge[0]) busOut <= byteSel ? rxMem[0][rxRd[0]][31:16] : rxMem[0][rxRd[0]][15:0];
         else if (rdEdge[1] && lblRdActive[1]) busOut <= {8'h0, lblMem[1][lblRd[1][3:0]]};
         else if (rdEdge[1]) busOut <= byteSel ? rxMem[1][rxRd[1]][31:16] : rxMem[1][rxRd[1]][15:0];
         else if (!statusReadN && !byteSel && rx1ReadStrobeN && rx2ReadStrobeN) busOut <= {7'h0, status};
      end
   end

   // Transmit FIFO loading
   assign txFull    = txCnt == awl_pkg::FIFO_DEPTH;
   assign txPush    = ldEdge[1] & ~ctrl[awl_pkg::LABEL_ACCESS] & ~txFull;
   assign txPop     = (txState == awl_pkg::TX_IDLE) & txGo & (txCnt != 6'h0);
   assign txWordOut = {ctrl[awl_pkg::TX_PARITY_IN] ? (~(^txMem[txRd][30:0]) ^ ctrl[awl_pkg::TX_PAR_EVEN])
                                                 : txMem[txRd][31], txMem[txRd][30:0]};
   always_ff @(posedge clock) begin
      if (clr) begin
         txHold <= 16'h0;
         txWr   <= 5'h0;
         txRd   <= 5'h0;
         txCnt  <= 6'h0;
      end else begin
         if (ldEdge[0] && !ctrl[awl_pkg::LABEL_ACCESS]) txHold <= busIn;
         if (txPush) begin
            txMem[txWr] <= {busIn, txHold};
            txWr <= txWr + 5'h1;
         end
         if (txPop) txRd <= txRd + 5'h1;
         if (txPush && !txPop) txCnt <= txCnt + 6'h1;
         else if (txPop && !txPush) txCnt <= txCnt - 6'h1;
      end
   end

   // Transmit serialiser
   always_ff @(posedge clock) begin
      if (clr) begin
         txState  <= awl_pkg::TX_IDLE;
         txShift  <= 32'h0;
         txPhase  <= 4'h0;
         txIdx    <= 5'h0;
         txGapCnt <= 6'h0;
      end else begin
         unique case (txState)
            awl_pkg::TX_IDLE: begin
               if (txPop) begin
                  txShift <= txWordOut;
                  txPhase <= 4'h0;
                  txIdx   <= 5'h0;
                  txState <= awl_pkg::TX_BIT;
               end
            end
            awl_pkg::TX_BIT: begin
               if (txTick && txPhase == awl_pkg::TX_BIT_LAST) begin
                  txPhase <= 4'h0;
                  txShift <= {1'b0, txShift[31:1]};
                  txIdx   <= txIdx + 5'h1;
                  if (txIdx == awl_pkg::WORD_LAST_BIT) begin
                     txState  <= awl_pkg::TX_GAP;
                     txGapCnt <= 6'h0;
                  end
               end else if (txTick) txPhase <= txPhase + 4'h1;
            end
            awl_pkg::TX_GAP: begin
               if (txTick && txGapCnt == awl_pkg::TX_GAP_LAST) txState <= awl_pkg::TX_IDLE;
               else if (txTick) txGapCnt <= txGapCnt + 6'h1;
            end
         endcase
      end
   end

   // Line levels, test input forces Null
   assign txOne  = (txState == awl_pkg::TX_BIT) & (txPhase < awl_pkg::TX_LEVEL_TICKS) & txShift[0];
   assign txZero = (txState == awl_pkg::TX_BIT) & (txPhase < awl_pkg::TX_LEVEL_TICKS) & ~txShift[0];
   always_ff @(posedge clock) begin
      if (clr) begin
         lineOutPos <= 1'b0;
         lineOutNeg <= 1'b0;
      end else begin
         lineOutPos <= txOne & ~testForceNull;
         lineOutNeg <= txZero & ~testForceNull;
      end
   end

   // Flag pins
   assign rx1WordAvailN = ~rdy[0];
   assign rx2WordAvailN = ~rdy[1];
   assign rx1FifoFullN  = ~rxFull[0];
   assign rx2FifoFullN  = ~rxFull[1];
   assign rx1FifoHalfN  = ~rxHalf[0];
   assign rx2FifoHalfN  = ~rxHalf[1];
   assign txFifoFullN   = ~txFull;
   assign txFifoHalfN   = ~(txCnt >= awl_pkg::HALF_MARK);
   assign txReady       = txCnt == 6'h0;

   // Checks
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_tx_start;
      txPop && !testForceNull && !masterClear ##1 !testForceNull && !masterClear;
   endsequence
   property p_tx_first_bit;
      s_tx_start |=> (lineOutPos || lineOutNeg);
   endproperty
   a_tx_first_bit: assert property (p_tx_first_bit) else $error("first bit late");
   property p_rx_overwrite;
      push[0] && rxFull[0] && !pop[0] && !masterClear |=> rxFull[0] && $stable(rxWr[0]);
   endproperty
   a_rx_overwrite: assert property (p_rx_overwrite) else $error("overflow grew fifo");
   property p_rx_half;
      push[0] && !pop[0] && rxCnt[0] == 6'h0f && !masterClear |=> !rx1FifoHalfN;
   endproperty
   a_rx_half: assert property (p_rx_half) else $error("half pin missed");
   property p_rx_ready;
      push[1] && !masterClear |=> !rx2WordAvailN;
   endproperty
   a_rx_ready: assert property (p_rx_ready) else $error("ready not set");
   property p_tx_full_ignore;
      ldEdge[1] && txFull && !txPop && !masterClear |=> $stable(txCnt);
   endproperty
   a_tx_full_ignore: assert property (p_tx_full_ignore) else $error("load taken when full");
   property p_test_null;
      testForceNull |=> !lineOutPos && !lineOutNeg;
   endproperty
   a_test_null: assert property (p_test_null) else $error("test not null");
   property p_master_clear;
      masterClear |=> rxCnt[0] == 6'h0 && rxCnt[1] == 6'h0 && txReady && txState == awl_pkg::TX_IDLE;
   endproperty
   a_master_clear: assert property (p_master_clear) else $error("clear incomplete");
   property p_status_read;
      !statusReadN && !byteSel && rx1ReadStrobeN && rx2ReadStrobeN && !masterClear |=> busOe && busOut[15:9] == 7'h0;
   endproperty
   a_status_read: assert property (p_status_read) else $error("status bus wrong");
   property p_bit_spacing;
      bitFire[0] && rxState[0] == awl_pkg::RX_WORD && badSpace[0] && !masterClear |=> rxState[0] == awl_pkg::RX_GAP;
   endproperty
   a_bit_spacing: assert property (p_bit_spacing) else $error("bad spacing kept");
endmodule

//--- sim/awl_line_src.sv
`timescale 1ns/1ps
// Serial word source on the receive line, high speed
module awl_line_src (
   // System
   input  wire logic clock,
   // Line levels
   output logic      lineOne,
   output logic      lineZero
);
   // Line rests at Null
   initial begin
      lineOne = 1'b0;
      lineZero = 1'b0;
   end
   // Long Null gap, then bit 1 first, 5 us level and 5 us Null
   task automatic send_word(input logic [31:0] w);
      repeat (1600) @(posedge clock);
      for (int i = 0; i < 32; i++) begin
         lineOne <= w[i];
         lineZero <= !w[i];
         repeat (200) @(posedge clock);
         lineOne <= 1'b0;
         lineZero <= 1'b0;
         repeat (200) @(posedge clock);
      end
   endtask
endmodule

//--- sim/tb.sv
`timescale 1ns/1ps
// Self-checking bench for the word link core
module tb;
   logic        clock = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
   logic        sel = 1'b0, rdN = 1'b1, ldLoN = 1'b1, ldHiN = 1'b1, one1, zero1, ack, lp, ln, txr;
   logic        mc = 1'b0, srN = 1'b1, tst = 1'b0, oe;
   logic        dr1N, dr2N, ff1N, ff2N, hf1N, hf2N, fftN, hftN;
   logic [3:0]  adr = 4'h0;
   logic [15:0] busIn = 16'h0, busOut;
   logic [31:0] wdat = 32'h0, rdat, wbOut, w, seen, lfsr = 32'h70ec;
   int          n_errors = 0, check_count = 0;
   awl_word_link uut (.clock(clock), .rst(rst), .masterClear(mc), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wbOut), .wb_ack_o(ack),
      .rxLineOne({2{one1}}), .rxLineZero({2{zero1}}), .busIn(busIn), .busOut(busOut), .busOe(oe),
      .byteSel(sel), .rx1ReadStrobeN(rdN), .rx2ReadStrobeN(1'b1), .txLoadLowN(ldLoN), .txLoadHighN(ldHiN),
      .statusReadN(srN), .txGo(go), .testForceNull(tst), .rx1WordAvailN(dr1N), .rx2WordAvailN(dr2N),
      .rx1FifoFullN(ff1N), .rx2FifoFullN(ff2N), .rx1FifoHalfN(hf1N), .rx2FifoHalfN(hf2N), .txFifoFullN(fftN),
      .txFifoHalfN(hftN), .txReady(txr), .wordEndPulse(), .lineOutPos(lp), .lineOutNeg(ln));
   awl_line_src src (.clock(clock), .lineOne(one1), .lineZero(zero1));
   // 40 MHz clock
   always #12.5 clock = ~clock;
   // Compare and count
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Shift register step for random words
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Classic single Wishbone cycle
   task automatic wb(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      {cyc, stb, we, adr, wdat} <= {2'b11, wr, a, d};
      do @(posedge clock); while (ack !== 1'b1);
      rdat = wbOut;
      {cyc, stb, we} <= 3'b000;
   endtask
   // One half read by receive strobe
   task automatic rd(input logic s, output logic [15:0] v);
      @(posedge clock);
      {sel, rdN} <= {s, 1'b0};
      repeat (3) @(posedge clock);
      v = busOut;
      rdN <= 1'b1;
      repeat (3) @(posedge clock);
   endtask
   // Low then high half transmit load
   task automatic ld(input logic [31:0] d);
      @(posedge clock);
      {busIn, ldLoN} <= {d[15:0], 1'b0};
      repeat (2) @(posedge clock);
      ldLoN <= 1'b1;
      repeat (2) @(posedge clock);
      {busIn, ldHiN} <= {d[31:16], 1'b0};
      repeat (2) @(posedge clock);
      ldHiN <= 1'b1;
      repeat (2) @(posedge clock);
   endtask
   // Verdict
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #2000000;
      n_errors++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      check("flags", {dr1N, dr2N, hf1N, hf2N, ff1N, ff2N, fftN, hftN, txr, lp, ln}, 11'h7fc);
      wb(1'b0, 4'h0, 32'h0);
      check("ctrl", rdat, 32'h30);
      wb(1'b0, 4'h8, 32'h0);
      check("unmapped", rdat, 32'h0);
      // Label memory: 16 loads per receiver, receiver 1 read back with select high
      wb(1'b1, 4'h0, 32'h32);
      for (int k = 0; k < 16; k++) ld({2{8'h0, 8'(k) ^ 8'h5a}});
      for (int k = 0; k < 16; k++) begin
         rd(1'b1, seen[15:0]);
         check("label", seen[15:0], {8'h0, 8'(k) ^ 8'h5a});
      end
      wb(1'b1, 4'h0, 32'h30);
      // Random word, then an even-parity corner
      for (int k = 0; k < 2; k++) begin
         lfsr = next_rand(lfsr);
         w = k ? 32'h3 : lfsr;
         src.send_word(w);
         repeat (2000) if (dr1N !== 1'b0) @(posedge clock);
         check("ready", dr1N, 1'b0);
         rd(1'b0, seen[15:0]);
         rd(1'b1, seen[31:16]);
         check("word", seen, {~^w, w[30:0]});
         check("empty", dr1N, 1'b1);
      end
      // Status word: receiver 2 holds two words, transmitter empty
      @(posedge clock);
      {sel, srN} <= 2'b00;
      repeat (3) @(posedge clock);
      check("status", {oe, busOut}, 17'h10048);
      srN <= 1'b1;
      // Master clear in mid-run empties FIFOs and flags, control kept
      mc <= 1'b1;
      @(posedge clock);
      mc <= 1'b0;
      repeat (2) @(posedge clock);
      check("mclear", {dr1N, dr2N, hf1N, hf2N, ff1N, ff2N, fftN, hftN, txr, lp, ln}, 11'h7fc);
      wb(1'b0, 4'h0, 32'h0);
      check("ctrlkept", rdat, 32'h30);
      // Bit 9/10 check on receiver 1 only: mismatching word dropped there
      wb(1'b1, 4'h0, 32'h70);
      src.send_word(32'h300);
      repeat (2000) @(posedge clock);
      check("filter", {dr1N, dr2N}, 2'b10);
      // Transmit one word and watch the first bit
      w = next_rand(lfsr);
      ld(w);
      check("txflags", {txr, hftN, fftN}, 3'b011);
      go <= 1'b1;
      repeat (100) if ({lp, ln} === 2'b00) @(posedge clock);
      check("firstbit", {lp, ln}, w[0] ? 2'b10 : 2'b01);
      tst <= 1'b1;
      repeat (2) @(posedge clock);
      check("testnull", {lp, ln}, 2'b00);
      check("txempty", txr, 1'b1);
      tally_and_finish();
   end
endmodule
